// ==== verilog/temp_sensor_bus_registers.sv ====
// Serial bus slave and register set of a window temperature sensor.
// Assumes scl and sda are sampled by a bus clock port, the master's bus
// clock, and that a temperature sample arrives on sample_temp_in.
//
// Notes on behaviour
// - Slave only; clock input, data line two-way.
// - Address is 10010 plus two strap pins.
// - Temperatures are 13-bit signed, 0.0625 degree steps.
// - Frequent reads starve temperature refresh.
// - Shutdown halts conversions and alarm outputs.
// - Bus and registers work during shutdown.
// - Shutdown acts a few system clocks after the config write.
// - Fault queue needs four faulted conversions.
// - Config bit 4 enables queue; bits 7:5 stored as written.
// - Selector resets to temperature, holds value.
// - Shutdown clears both alarms; reads clear window.
// - Temperature register ignores writes.
// - Reads use latched selector or repeated start.
// - High byte first, high bit first.
// - Final read byte accepts ack or nack.
// - Stuck data line released by clocks, stop.
// - Select field picks one of seven registers.
// - Temperature word holds data and three flags.
// - Config bit0 shutdown, bit1 event mode.
// - Config bits2,3 set alarm polarities.
// - Any read restarts the running conversion.
// - Comparator mode read clears, next conversion sets.
// - Event mode asserts on crossings only.
// - Flags follow limits with hysteresis.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_bus_registers
    import temp_sensor_pkg::*;
#(
    parameter int          CONV_CYC = CONV_CYCLES,   // Conversion length
    parameter logic [15:0] IDENT    = 16'h5A5A       // Arbitrary value
) (
    input  wire logic        clk_in,              // System clock
    input  wire logic        srst_in,             // Synchronous reset
    input  wire logic        scl_in,              // Bus clock, link domain
    input  wire logic        sda_in,              // Bus data level
    output logic             sda_out,             // Bus data drive value
    output logic             sda_oe_out,          // Bus data drive enable
    input  wire logic [1:0]  address_strap_pins,  // Low address bits
    input  wire logic [12:0] sample_temp_in,      // Measured temperature
    output logic             window_alarm_out,    // Window alarm level
    output logic             critical_alarm_output, // Critical alarm level
    output logic             converting_out       // Converter running
);
    import temp_sensor_pkg::*;

    // ==================================================================
    // Bus domain: start, stop, bytes, acknowledge.
    // ==================================================================
    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_PTR, B_WDATA, B_RDATA, B_IGNORE
    } bus_state_type;

    bus_state_type bus_state_reg  = B_IDLE;
    logic [7:0]    shift_reg;
    logic [7:0]    byte_bus;
    logic [3:0]    bit_reg        = 4'h0;
    logic          ack_phase_reg  = 1'b0;
    logic          ack_drive_reg  = 1'b0;
    logic [7:0]    tx_reg         = 8'h00;
    logic          first_byte_reg = 1'b1;
    logic          start_tgl_reg  = 1'b0;
    logic          stop_tgl_reg   = 1'b0;
    logic          ev_tgl_reg     = 1'b0;
    bus_event_type ev_reg;
    logic          rd_tgl_reg     = 1'b0;
    logic          sda_drv_reg    = 1'b1;
    logic          sda_en_reg     = 1'b0;
    logic [15:0]   rd_word_bus;

    // Start and stop are seen on data edges while the bus clock is high.
    always_ff @(negedge sda_in) begin
        if (scl_in) begin
            start_tgl_reg <= !start_tgl_reg;
        end
    end

    always_ff @(posedge sda_in) begin
        if (scl_in) begin
            stop_tgl_reg <= !stop_tgl_reg;
        end
    end

    logic start_seen_reg;
    logic stop_seen_reg;
    logic start_last_reg = 1'b0;
    logic stop_last_reg  = 1'b0;

    assign start_seen_reg = start_tgl_reg != start_last_reg;
    assign stop_seen_reg  = stop_tgl_reg != stop_last_reg;

    assign byte_bus = {shift_reg[6:0], sda_in};

    always_ff @(posedge scl_in) begin
        start_last_reg <= start_tgl_reg;
        stop_last_reg  <= stop_tgl_reg;
        if (start_seen_reg || stop_seen_reg) begin
            bus_state_reg  <= start_seen_reg ? B_ADDR : B_IDLE;
            bit_reg        <= 4'h1;
            shift_reg      <= {7'h00, sda_in};
            ack_phase_reg  <= 1'b0;
            first_byte_reg <= 1'b1;
        end else if (bus_state_reg == B_IDLE ||
                     bus_state_reg == B_IGNORE) begin
            bit_reg <= 4'h0;
        end else if (ack_phase_reg) begin
            ack_phase_reg <= 1'b0;
            bit_reg       <= 4'h0;
            if (bus_state_reg == B_RDATA && sda_in) begin
                bus_state_reg <= B_IGNORE;
            end
        end else if (bit_reg == 4'h7) begin
            // Eighth bit: decide on the whole byte, answer in the ninth.
            ack_phase_reg <= 1'b1;
            ack_drive_reg <= 1'b1;
            bit_reg       <= 4'h8;
            shift_reg     <= byte_bus;
            case (bus_state_reg)
                B_ADDR: begin
                    if (byte_bus[7:3] == ADDR_FIXED_BITS &&
                        byte_bus[2:1] == address_strap_pins) begin
                        bus_state_reg <= byte_bus[0] ? B_RDATA : B_PTR;
                        if (byte_bus[0]) begin
                            rd_tgl_reg <= !rd_tgl_reg;
                        end
                    end else begin
                        bus_state_reg <= B_IGNORE;
                        ack_drive_reg <= 1'b0;
                    end
                end
                B_PTR: begin
                    ev_reg        <= '{1'b1, 1'b1, byte_bus};
                    ev_tgl_reg    <= !ev_tgl_reg;
                    bus_state_reg <= B_WDATA;
                end
                B_WDATA: begin
                    ev_reg     <= '{1'b1, 1'b0, byte_bus};
                    ev_tgl_reg <= !ev_tgl_reg;
                end
                default: begin
                    first_byte_reg <= 1'b0;
                    ack_drive_reg  <= 1'b0;
                end
            endcase
        end else begin
            bit_reg   <= bit_reg + 4'h1;
            shift_reg <= byte_bus;
        end
    end

    // Data changes while the bus clock is low.
    always_ff @(negedge scl_in) begin
        if (ack_phase_reg && ack_drive_reg) begin
            sda_en_reg  <= 1'b1;
            sda_drv_reg <= 1'b0;
        end else if (bus_state_reg == B_RDATA && !ack_phase_reg) begin
            if (bit_reg == 4'h0) begin
                tx_reg <= {(first_byte_reg ? rd_word_bus[14:8]
                                           : rd_word_bus[6:0]), 1'b0};
                sda_drv_reg <= first_byte_reg ? rd_word_bus[15]
                                              : rd_word_bus[7];
            end else begin
                sda_drv_reg <= tx_reg[7];
                tx_reg      <= {tx_reg[6:0], 1'b0};
            end
            sda_en_reg <= 1'b1;
        end else begin
            sda_en_reg  <= 1'b0;
            sda_drv_reg <= 1'b1;
        end
    end

    assign sda_out    = sda_drv_reg;
    assign sda_oe_out = sda_en_reg;

    // ==================================================================
    // Crossing into the system clock domain.
    // ==================================================================
    logic ev_tgl_sync;
    logic rd_tgl_sync;
    logic ev_tgl_last_reg;
    logic rd_tgl_last_reg;
    logic ev_pulse;
    logic rd_pulse;

    sync_bit ev_sync (.clk_in(clk_in), .srst_in(srst_in),
        .d_in(ev_tgl_reg), .q_out(ev_tgl_sync));

    sync_bit rd_sync (.clk_in(clk_in), .srst_in(srst_in),
        .d_in(rd_tgl_reg), .q_out(rd_tgl_sync));

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ev_tgl_last_reg <= 1'b0;
            rd_tgl_last_reg <= 1'b0;
        end else begin
            ev_tgl_last_reg <= ev_tgl_sync;
            rd_tgl_last_reg <= rd_tgl_sync;
        end
    end

    assign ev_pulse = ev_tgl_sync != ev_tgl_last_reg;
    assign rd_pulse = rd_tgl_sync != rd_tgl_last_reg;

    // ==================================================================
    // Register file in the system domain.
    // ==================================================================
    logic [7:0]  register_selector_reg;
    logic [7:0]  config_control_reg;
    logic [12:0] hysteresis_setpoint_reg;
    logic [12:0] critical_setpoint_reg;
    logic [12:0] lower_setpoint_reg;
    logic [12:0] upper_setpoint_reg;
    logic [12:0] temperature_result_reg;
    logic [7:0]  high_byte_reg;
    logic        high_pending_reg;
    logic [15:0] rd_word_reg;
    logic        critical_status_flag_flag;
    logic        upper_flag;
    logic        lower_flag;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            register_selector_reg   <= SELECTOR_RESET;
            config_control_reg      <= CONFIG_RESET;
            hysteresis_setpoint_reg <= HYST_RESET;
            critical_setpoint_reg   <= CRITICAL_STATUS_FLAG_RESET;
            lower_setpoint_reg      <= LOWER_RESET;
            upper_setpoint_reg      <= UPPER_RESET;
            high_byte_reg           <= 8'h00;
            high_pending_reg        <= 1'b0;
        end else if (ev_pulse) begin
            if (ev_reg.is_pointer) begin
                register_selector_reg <= ev_reg.data;
                high_pending_reg      <= 1'b1;
            end else if (register_selector_reg[2:0] == SEL_CONFIG) begin
                config_control_reg <= ev_reg.data;
            end else if (high_pending_reg) begin
                high_byte_reg    <= ev_reg.data;
                high_pending_reg <= 1'b0;
            end else begin
                high_pending_reg <= 1'b1;
                case (register_selector_reg[2:0])
                    SEL_HYSTERESIS: hysteresis_setpoint_reg <=
                        {high_byte_reg, ev_reg.data[7:3]};
                    SEL_CRITICAL: critical_setpoint_reg <=
                        {high_byte_reg, ev_reg.data[7:3]};
                    SEL_LOWER: lower_setpoint_reg <=
                        {high_byte_reg, ev_reg.data[7:3]};
                    SEL_UPPER: upper_setpoint_reg <=
                        {high_byte_reg, ev_reg.data[7:3]};
                    default: high_pending_reg <= 1'b1;
                endcase
            end
        end
    end

    // Read word, reloaded every system clock from the selected register.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_word_reg <= 16'h0000;
        end else begin
            case (register_selector_reg[2:0])
                SEL_TEMPERATURE: rd_word_reg <= {temperature_result_reg,
                    critical_status_flag_flag, upper_flag, lower_flag};
                SEL_CONFIG: rd_word_reg <= {config_control_reg, 8'h00};
                SEL_HYSTERESIS: rd_word_reg <= {hysteresis_setpoint_reg, 3'h0};
                SEL_CRITICAL: rd_word_reg <= {critical_setpoint_reg, 3'h0};
                SEL_LOWER: rd_word_reg <= {lower_setpoint_reg, 3'h0};
                SEL_UPPER: rd_word_reg <= {upper_setpoint_reg, 3'h0};
                SEL_IDENT: rd_word_reg <= IDENT;
                default: rd_word_reg <= 16'h0000;
            endcase
        end
    end

    // Word is quasi-static while a read is in progress.
    assign rd_word_bus = rd_word_reg;

    // ==================================================================
    // Conversion timer and alarms.
    // ==================================================================
    logic        shutdown;
    logic        sample;
    logic [31:0] conv_cnt_reg;
    logic        upper_rise;
    logic        lower_rise;
    logic        window_reg;

    assign shutdown = config_control_reg[CFG_SHUTDOWN_BIT];
    assign sample   = !shutdown && conv_cnt_reg == 32'(CONV_CYC - 1);

    always_ff @(posedge clk_in) begin
        if (srst_in || shutdown || rd_pulse) begin
            conv_cnt_reg <= 32'h0;
        end else if (sample) begin
            conv_cnt_reg <= 32'h0;
        end else begin
            conv_cnt_reg <= conv_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            temperature_result_reg <= 13'h0000;
        end else if (sample) begin
            temperature_result_reg <= sample_temp_in;
        end
    end

    alarm_comparator critical_status_flag_cmp (
        .clk_in(clk_in), .srst_in(srst_in), .sample_in(sample),
        .below_in(1'b0), .queue_in(config_control_reg[CFG_FAULT_Q_BIT]),
        .temp_in(sample_temp_in), .limit_in(critical_setpoint_reg),
        .hyst_in(hysteresis_setpoint_reg), .flag_out(critical_status_flag_flag),
        .rise_out()
    );

    alarm_comparator upper_cmp (
        .clk_in(clk_in), .srst_in(srst_in), .sample_in(sample),
        .below_in(1'b0), .queue_in(config_control_reg[CFG_FAULT_Q_BIT]),
        .temp_in(sample_temp_in), .limit_in(upper_setpoint_reg),
        .hyst_in(hysteresis_setpoint_reg), .flag_out(upper_flag),
        .rise_out(upper_rise)
    );

    alarm_comparator lower_cmp (
        .clk_in(clk_in), .srst_in(srst_in), .sample_in(sample),
        .below_in(1'b1), .queue_in(config_control_reg[CFG_FAULT_Q_BIT]),
        .temp_in(sample_temp_in), .limit_in(lower_setpoint_reg),
        .hyst_in(hysteresis_setpoint_reg), .flag_out(lower_flag),
        .rise_out(lower_rise)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in || shutdown) begin
            window_reg <= 1'b0;
        end else if (config_control_reg[CFG_EVENT_MODE_BIT]) begin
            if (upper_rise || lower_rise) begin
                window_reg <= 1'b1;
            end else if (rd_pulse) begin
                window_reg <= 1'b0;
            end
        end else if (sample) begin
            window_reg <= upper_flag || lower_flag;
        end else if (rd_pulse) begin
            window_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            window_alarm_out      <= 1'b1;
            critical_alarm_output <= 1'b1;
            converting_out        <= 1'b0;
        end else begin
            window_alarm_out <= window_reg ~^
                config_control_reg[CFG_WIN_POL_BIT];
            critical_alarm_output <= (critical_status_flag_flag && !shutdown) ~^
                config_control_reg[CFG_CRITICAL_STATUS_FLAG_POL_BIT];
            converting_out <= !shutdown;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/temp_sensor_pkg.sv ====
// Shared constants and carrier types for the temperature sensor bus block.
// Assumes one system clock domain plus the serial bus clock from the master.
package temp_sensor_pkg;

    localparam logic [4:0]  ADDR_FIXED_BITS = 5'h12;
    localparam logic [2:0]  SEL_TEMPERATURE = 3'h0;
    localparam logic [2:0]  SEL_CONFIG      = 3'h1;
    localparam logic [2:0]  SEL_HYSTERESIS  = 3'h2;
    localparam logic [2:0]  SEL_CRITICAL    = 3'h3;
    localparam logic [2:0]  SEL_LOWER       = 3'h4;
    localparam logic [2:0]  SEL_UPPER       = 3'h5;
    localparam logic [2:0]  SEL_IDENT       = 3'h7;

    localparam int CFG_SHUTDOWN_BIT   = 0;
    localparam int CFG_EVENT_MODE_BIT = 1;
    localparam int CFG_CRITICAL_STATUS_FLAG_POL_BIT   = 2;
    localparam int CFG_WIN_POL_BIT    = 3;
    localparam int CFG_FAULT_Q_BIT    = 4;

    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  SELECTOR_RESET  = 8'h00;
    // Setpoints at reset, 13-bit two's complement in 0.0625 degree steps.
    localparam logic [12:0] HYST_RESET      = 13'h0020;
    localparam logic [12:0] CRITICAL_STATUS_FLAG_RESET      = 13'h0500;
    localparam logic [12:0] LOWER_RESET     = 13'h00A0;
    localparam logic [12:0] UPPER_RESET     = 13'h0400;
    localparam int          FAULT_COUNT     = 4;

    // Clock rate and conversion period used for the sample timer.
    localparam int          CLK_MHZ         = 250;
    localparam int          CONV_PERIOD_US  = 100;
    localparam int          CONV_CYCLES     = CONV_PERIOD_US * CLK_MHZ;

    // One byte event crossing from the bus domain into the system domain.
    typedef struct packed {
        logic       is_write;
        logic       is_pointer;
        logic [7:0] data;
    } bus_event_type;

endpackage

// ==== verilog/sync_bit.sv ====
// Two-stage synchroniser for a single level.
// Assumes the destination clock is clk_in.
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
    input  wire logic clk_in,   // Destination clock
    input  wire logic srst_in,  // Synchronous reset
    input  wire logic d_in,     // Asynchronous level
    output logic      q_out     // Synchronised level
);
    logic stage1_reg;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stage1_reg <= 1'b0;
            q_out      <= 1'b0;
        end else begin
            stage1_reg <= d_in;
            q_out      <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/alarm_comparator.sv ====
// Hysteresis comparator with fault queue for one limit.
// Assumes sample_in pulses once per finished conversion.
`timescale 1ns/1ps
`default_nettype none
module alarm_comparator
    import temp_sensor_pkg::*;
(
    input  wire logic        clk_in,     // System clock
    input  wire logic        srst_in,    // Synchronous reset
    input  wire logic        sample_in,  // Conversion done pulse
    input  wire logic        below_in,   // 1 for a lower limit
    input  wire logic        queue_in,   // Fault queue enabled
    input  wire logic [12:0] temp_in,    // New sample
    input  wire logic [12:0] limit_in,   // Limit value
    input  wire logic [12:0] hyst_in,    // Hysteresis value
    output logic             flag_out,   // Status flag
    output logic             rise_out    // Event crossing pulse
);
    import temp_sensor_pkg::*;

    logic signed [13:0] t_s;
    logic signed [13:0] trip_s;
    logic signed [13:0] clear_s;
    logic               fault;
    logic               clear;
    logic [2:0]         count_reg;

    assign t_s    = {temp_in[12], temp_in};
    assign trip_s = {limit_in[12], limit_in};
    assign clear_s = below_in ? trip_s + {hyst_in[12], hyst_in}
                              : trip_s - {hyst_in[12], hyst_in};
    assign fault  = below_in ? (t_s < trip_s) : (t_s > trip_s);
    assign clear  = below_in ? (t_s > clear_s) : (t_s < clear_s);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= 3'h0;
        end else if (sample_in) begin
            if (!fault) begin
                count_reg <= 3'h0;
            end else if (count_reg != 3'(FAULT_COUNT)) begin
                count_reg <= count_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_out <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            if (sample_in) begin
                if (!flag_out && fault &&
                    (!queue_in || count_reg == 3'(FAULT_COUNT - 1))) begin
                    flag_out <= 1'b1;
                    rise_out <= 1'b1;
                end else if (flag_out && clear) begin
                    flag_out <= 1'b0;
                    rise_out <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/temp_sensor_sva.sv ====
// Checker on the sensor block ports in the system clock domain.
// Assumes default alarm polarity and critical setpoint in the run.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_sva
    import temp_sensor_pkg::*;
(
    input wire logic        clk_in,                // Clock
    input wire logic        srst_in,               // Reset
    input wire logic        scl_in,                // Bus clock
    input wire logic        sda_out,               // Data value
    input wire logic        sda_oe_out,            // Data enable
    input wire logic [12:0] sample_temp_in,        // Sample
    input wire logic        window_alarm_out,      // Alarm
    input wire logic        critical_alarm_output, // Alarm
    input wire logic        converting_out         // Running
);
    // ====
    // Properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_off;
        window_alarm_out && critical_alarm_output;
    endsequence
    property p_oe; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_oe: assert property (p_oe) else $error("enable moved");
    property p_bit; sda_oe_out && $changed(sda_out) |-> !scl_in; endproperty
    a_bit: assert property (p_bit) else $error("bit moved");
    property p_rst; $fell(srst_in) |-> s_off; endproperty
    a_rst: assert property (p_rst) else $error("alarm at reset");
    property p_run; $fell(srst_in) |-> !converting_out ##1 converting_out;
    endproperty
    a_run: assert property (p_run) else $error("not running");
    property p_sd; $fell(converting_out) |-> ##[0:1] s_off; endproperty
    a_sd: assert property (p_sd) else $error("alarm kept");
    property p_quiet; !converting_out [*2] |-> s_off; endproperty
    a_quiet: assert property (p_quiet) else $error("alarm on");
    property p_hot;
        $fell(critical_alarm_output) |->
            $signed(sample_temp_in) > $signed(CRITICAL_STATUS_FLAG_RESET);
    endproperty
    a_hot: assert property (p_hot) else $error("alarm cool");
    property p_live; $fell(window_alarm_out) |-> converting_out; endproperty
    a_live: assert property (p_live) else $error("alarm off");
    c_sd: cover property ($fell(converting_out));
    c_critical_status_flag: cover property ($fell(critical_alarm_output));
    c_win: cover property ($fell(window_alarm_out));
endmodule
`default_nettype wire

// ==== testbench/bus_master_model.sv ====
// Bus master model: makes the bus clock and pulls data low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic sda_in,     // Data line
    output var  logic scl_out,    // Bus clock
    output var  logic sda_low_out // Pull low
);
    // ====
    // Bus primitives, 160 ns bit
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic start_c();
        sda_low_out = 1'b0;
        #40 scl_out = 1'b1;
        #40 sda_low_out = 1'b1;
        #40 scl_out = 1'b0;
        #40;
    endtask
    task automatic stop_c();
        sda_low_out = 1'b1;
        #40 scl_out = 1'b1;
        #40 sda_low_out = 1'b0;
        #80;
    endtask
    task automatic bit_c(input logic b, output logic s);
        sda_low_out = ~b;
        #40 scl_out = 1'b1;
        #40 s = sda_in;
        #40 scl_out = 1'b0;
        #40;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, ack_n);
        #200;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(last, s);
        #200;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Bench for the sensor bus block through a bus master model.
// Assumes package, design and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import temp_sensor_pkg::*;
    localparam logic [15:0] ID = 16'h3C3C; // Arbitrary value.
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [1:0]  straps = 2'h2;
    logic [12:0] temp = 13'h0190;
    logic        scl, sda_low, sda, sda_out, sda_oe, win, critical_status_flag, conv;
    int          n_fail = 0;
    int          checked = 0;
    // ====
    // Wiring
    always #2 clk_in = ~clk_in;
    assign sda = ~(sda_low | (sda_oe & ~sda_out));
    temp_sensor_bus_registers #(.CONV_CYC(20), .IDENT(ID))
        temp_sensor_bus_registers_inst (
        .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .sample_temp_in(temp),
        .address_strap_pins(straps), .window_alarm_out(win),
        .critical_alarm_output(critical_status_flag), .converting_out(conv));
    bus_master_model m (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    // ====
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic [2:0] sel, input logic rd);
        logic a;
        m.start_c();
        m.put_byte({ADDR_FIXED_BITS, straps, 1'b0}, a);
        check(16'(a), 16'h0);
        m.put_byte({5'h00, sel}, a);
        if (rd) begin
            m.start_c();
            m.put_byte({ADDR_FIXED_BITS, straps, 1'b1}, a);
        end
    endtask
    task automatic wr(input logic [2:0] sel, input logic [15:0] d, input bit two);
        logic a;
        go(sel, 1'b0);
        if (two) begin
            m.put_byte(d[15:8], a);
        end
        m.put_byte(d[7:0], a);
        m.stop_c();
    endtask
    task automatic rd(input logic [2:0] sel, output logic [15:0] d);
        go(sel, 1'b1);
        m.get_byte(1'b0, d[15:8]);
        m.get_byte(1'b1, d[7:0]);
        m.stop_c();
    endtask
    task automatic s_defaults();
        logic [15:0] d;
        logic [12:0] lim [4];
        lim = '{HYST_RESET, CRITICAL_STATUS_FLAG_RESET, LOWER_RESET, UPPER_RESET};
        rd(SEL_CONFIG, d);
        check(d, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd(SEL_HYSTERESIS + 3'(i), d);
            check(d >> 3, 16'(lim[i]));
        end
        rd(SEL_IDENT, d);
        check(d, ID);
    endtask
    task automatic s_regs();
        logic [15:0] d;
        logic        a;
        wr(SEL_UPPER, 16'h0A18, 1'b1);
        rd(SEL_UPPER, d);
        check(d >> 3, 16'h0143);
        wr(SEL_UPPER, {UPPER_RESET, 3'h0}, 1'b1);
        wr(SEL_TEMPERATURE, 16'hFFF8, 1'b1);
        rd(SEL_TEMPERATURE, d);
        check(d, {13'h0190, 3'h0});
        m.start_c();
        m.put_byte({ADDR_FIXED_BITS, straps, 1'b1}, a);
        m.get_byte(1'b0, d[15:8]);
        m.get_byte(1'b1, d[7:0]);
        m.stop_c();
        check(d, {13'h0190, 3'h0});
        m.start_c();
        m.put_byte({ADDR_FIXED_BITS, ~straps, 1'b0}, a);
        m.stop_c();
        check(16'(a), 16'h1);
    endtask
    task automatic s_shutdown();
        logic [15:0] d;
        @(posedge clk_in);
        #1 temp = 13'h0590;
        repeat (100) @(posedge clk_in);
        check(16'(critical_status_flag), 16'h0);
        rd(SEL_TEMPERATURE, d);
        check(d, {13'h0590, 3'h6});
        wr(SEL_CONFIG, 16'h0001, 1'b0);
        repeat (50) @(posedge clk_in);
        check({13'h0, conv, win, critical_status_flag}, 16'h0003);
        rd(SEL_CONFIG, d);
        check(d, 16'h0100);
        wr(SEL_CONFIG, 16'h0000, 1'b0);
        repeat (100) @(posedge clk_in);
        check(16'(critical_status_flag), 16'h0);
        @(posedge clk_in);
        #1 temp = 13'h0190;
        repeat (100) @(posedge clk_in);
        check(16'(critical_status_flag), 16'h1);
    endtask
    task automatic s_queue();
        logic [15:0] d;
        wr(SEL_CONFIG, 16'h0010, 1'b0);
        rd(SEL_CONFIG, d);
        check(d, 16'h1000);
        @(posedge clk_in);
        #1 temp = 13'h0590;
        repeat (50) @(posedge clk_in);
        check(16'(critical_status_flag), 16'h1);
        repeat (100) @(posedge clk_in);
        check(16'(critical_status_flag), 16'h0);
    endtask
    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ====
    // Sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_in);
        #1 srst_in = 1'b0;
        repeat (3) @(posedge clk_in);
        s_defaults();
        s_regs();
        s_shutdown();
        s_queue();
        results();
    end
    initial begin
        #300000;
        n_fail++;
        results();
    end
endmodule
bind temp_sensor_bus_registers temp_sensor_sva temp_sensor_sva_inst (
    .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .sample_temp_in(sample_temp_in),
    .window_alarm_out(window_alarm_out), .converting_out(converting_out),
    .critical_alarm_output(critical_alarm_output));
`default_nettype wire
